// [include/amsd_pkg.sv]
package amsd_pkg;

    // ------------------------------------------------------------------
    // bundle geometry
    // ------------------------------------------------------------------
    localparam int BUNDLE_W = 166;
    localparam int BODY_W   = 160;
    localparam int SUB_W    = 40;
    localparam int SUB_NUM  = 4;
    localparam int BODY_LSB = 5;
    localparam int CTRL_BIT = 165;

    // ------------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_SPATIAL = 8'h04;
    localparam logic [7:0] OFS_SUB0    = 8'h08;
    localparam logic [7:0] OFS_COMMIT  = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;

    // ------------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] streamCountMinusOne;
        logic [1:0] viewCount;
        logic       passThrough;
        logic       spatialAudioSelect;
    } amsd_ctrl_s;

    typedef struct packed {
        logic [7:0] spatialSpeakerAlloc;
        logic [3:0] channelAllocStandard;
        logic [4:0] spatialChannelCount;
    } amsd_spatial_s;

    typedef struct packed {
        logic [23:0] languageTag;
        logic        languageTagValid;
        logic        supplPresent;
        logic        supplMixed;
        logic [2:0]  supplType;
        logic        viewRight;
        logic        viewLeft;
    } amsd_sub_s;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam amsd_ctrl_s    CTRL_RST    = 6'h02;
    localparam amsd_spatial_s SPATIAL_RST = 17'h00000;
    localparam amsd_sub_s     SUB_RST     = 32'h00000000;
    localparam logic [BUNDLE_W-1:0] BUNDLE_RST =
        {1'b1, {(BUNDLE_W-1){1'b0}}};

    // ------------------------------------------------------------------
    // ahb-lite codes
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// [hw/amsd_host.sv]
`timescale 1ns/1ps
module amsd_host #(
    parameter int FIFO_DEPTH   = 2,
    parameter bit VSYNC_ACTIVE = 1'b1
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output      logic                          hreadyout,
    output      logic                          hresp,
    output      logic [31:0]                   hrdata,
    input  wire logic                          vsync,
    output      logic [amsd_pkg::BUNDLE_W-1:0] metadataBundle
);

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    initial begin
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
            $error("FIFO_DEPTH must be a power of two of at least 2");
    end

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    logic                   actQ;
    logic                   wrQ;
    logic [7:0]             addrQ;
    logic [31:0]            rdQ;
    amsd_pkg::amsd_ctrl_s    ctrlQ;
    amsd_pkg::amsd_spatial_s spatialQ;
    amsd_pkg::amsd_sub_s     subQ [amsd_pkg::SUB_NUM];
    logic                   dropQ;
    logic [7:0]             fieldCntQ;
    logic [31:0]            rdMux;
    logic                   addrPhase;
    logic                   wrData;
    logic                   wrCtrl;
    logic                   wrSpatial;
    logic                   wrCommit;
    logic                   wrStatus;
    logic                   inReady;
    logic                   outValid;
    logic [CW-1:0]          countQ;
    logic                   pop;

    assign hreadyout = 1'b1;   // zero wait states
    assign hresp     = 1'b0;   // always okay
    assign hrdata    = rdQ;
    assign addrPhase = hsel & hready & (htrans == amsd_pkg::HTRANS_NONSEQ);
    assign wrData    = actQ & wrQ;
    assign wrCtrl    = wrData & (addrQ == amsd_pkg::OFS_CTRL);
    assign wrSpatial = wrData & (addrQ == amsd_pkg::OFS_SPATIAL);
    assign wrCommit  = wrData & (addrQ == amsd_pkg::OFS_COMMIT);
    assign wrStatus  = wrData & (addrQ == amsd_pkg::OFS_STATUS);

    // read mux, unmapped words read zero
    always_comb begin
        rdMux = 32'h00000000;
        case (haddr[7:0])
            amsd_pkg::OFS_CTRL:    rdMux = {26'h0000000, ctrlQ};
            amsd_pkg::OFS_SPATIAL: rdMux = {15'h0000, spatialQ};
            amsd_pkg::OFS_STATUS:
                rdMux = {16'h0000, fieldCntQ, 3'h0, dropQ,
                         metadataBundle[amsd_pkg::CTRL_BIT],
                         outValid, inReady,
                         metadataBundle[0]};
            default: begin
                for (int k = 0; k < amsd_pkg::SUB_NUM; k++) begin
                    if (haddr[7:0] == amsd_pkg::OFS_SUB0 + 8'(4 * k))
                        rdMux = subQ[k];
                end
            end
        endcase
    end

    // address phase capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            actQ  <= 1'b0;
            wrQ   <= 1'b0;
            addrQ <= 8'h00;
            rdQ   <= 32'h00000000;
        end else if (hready) begin
            actQ  <= addrPhase;
            wrQ   <= hwrite;
            addrQ <= haddr[7:0];
            if (addrPhase && !hwrite)
                rdQ <= rdMux;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlQ    <= amsd_pkg::CTRL_RST;
            spatialQ <= amsd_pkg::SPATIAL_RST;
        end else begin
            if (wrCtrl)
                ctrlQ <= hwdata[5:0];
            if (wrSpatial)
                spatialQ <= hwdata[16:0];
        end
    end

    generate
        for (genvar s = 0; s < amsd_pkg::SUB_NUM; s++) begin : g_subReg
            always_ff @(posedge clk or posedge rst) begin
                if (rst)
                    subQ[s] <= amsd_pkg::SUB_RST;
                else if (wrData && addrQ == amsd_pkg::OFS_SUB0 + 8'(4 * s))
                    subQ[s] <= hwdata;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // bundle assembly
    // ------------------------------------------------------------------
    logic [amsd_pkg::BODY_W-1:0]   spatialBody;
    logic [amsd_pkg::BODY_W-1:0]   multiBody;
    logic [amsd_pkg::BUNDLE_W-1:0] builtBundle;

    // spatial layout, every reserved bit zero
    assign spatialBody = {136'h0,
                          spatialQ.spatialSpeakerAlloc, 4'h0,
                          spatialQ.channelAllocStandard, 3'h0,
                          spatialQ.spatialChannelCount};

    // one forty-bit slice per subpacket
    generate
        for (genvar s = 0; s < amsd_pkg::SUB_NUM; s++) begin : g_multi
            assign multiBody[amsd_pkg::SUB_W*s +: amsd_pkg::SUB_W] =
                {subQ[s].languageTag,
                 subQ[s].languageTagValid, 2'h0,
                 subQ[s].supplPresent, subQ[s].supplMixed,
                 subQ[s].supplType, 6'h00,
                 subQ[s].viewRight, subQ[s].viewLeft};
        end
    endgenerate

    // header and control bit around the selected body
    assign builtBundle = {ctrlQ.passThrough,
                          ctrlQ.spatialAudioSelect ? spatialBody : multiBody,
                          ctrlQ.streamCountMinusOne,
                          ctrlQ.viewCount,
                          ctrlQ.spatialAudioSelect};

    // ------------------------------------------------------------------
    // bundle buffer of FIFO_DEPTH entries, two by default
    // ------------------------------------------------------------------
    logic [amsd_pkg::BUNDLE_W-1:0] mem [FIFO_DEPTH];
    logic [PW-1:0]                 wrPtrQ;
    logic [PW-1:0]                 rdPtrQ;
    logic                          push;
    logic                          outReady;

    assign inReady  = (countQ != CW'(FIFO_DEPTH));
    assign outValid = (countQ != '0);
    assign push     = wrCommit & inReady;
    assign pop      = outValid & outReady;

    always_ff @(posedge clk) begin
        if (push)
            mem[wrPtrQ] <= builtBundle;
    end

    // pointers and fill level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end else begin
            if (push)
                wrPtrQ <= wrPtrQ + 1'b1;
            if (pop)
                rdPtrQ <= rdPtrQ + 1'b1;
            countQ <= countQ + CW'(push) - CW'(pop);
        end
    end

    // overflow flag, a refused commit wins over a status clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            dropQ <= 1'b0;
        else if (wrCommit && !inReady)
            dropQ <= 1'b1;
        else if (wrStatus && hwdata[4])
            dropQ <= 1'b0;
    end

    // ------------------------------------------------------------------
    // field sync and bundle update
    // ------------------------------------------------------------------
    logic vsyncPin;
    logic vsyncMetaQ;
    logic vsyncSyncQ;
    logic vsyncLastQ;

    assign vsyncPin = vsync ~^ VSYNC_ACTIVE;
    assign outReady = vsyncSyncQ & ~vsyncLastQ;

    // two-flop synchroniser plus edge stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vsyncMetaQ <= 1'b0;
            vsyncSyncQ <= 1'b0;
            vsyncLastQ <= 1'b0;
        end else begin
            vsyncMetaQ <= vsyncPin;
            vsyncSyncQ <= vsyncMetaQ;
            vsyncLastQ <= vsyncSyncQ;
        end
    end

    // bundle changes only at a field edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            metadataBundle <= amsd_pkg::BUNDLE_RST;
            fieldCntQ      <= 8'h00;
        end else if (pop) begin
            metadataBundle <= mem[rdPtrQ];
            fieldCntQ      <= fieldCntQ + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_layout_select: assert property (
        push |=> mem[$past(wrPtrQ)][0] == $past(ctrlQ.spatialAudioSelect))
        else $error("layout bit does not follow control");
    a_view_count: assert property (
        push |=> mem[$past(wrPtrQ)][2:1] == $past(ctrlQ.viewCount))
        else $error("view count misplaced");
    a_stream_count: assert property (
        push |=> mem[$past(wrPtrQ)][4:3]
                 == $past(ctrlQ.streamCountMinusOne))
        else $error("stream count misplaced");
    a_bypass_bit: assert property (
        push |=> mem[$past(wrPtrQ)][amsd_pkg::CTRL_BIT]
                 == $past(ctrlQ.passThrough))
        else $error("pass-through bit misplaced");
    a_spatial_reserved: assert property (
        builtBundle[0] |-> builtBundle[164:29] == '0
            && builtBundle[12:10] == '0 && builtBundle[20:17] == '0
            && builtBundle[9:5] == spatialQ.spatialChannelCount)
        else $error("spatial reserved bits not zero");
    a_alloc_std: assert property (
        builtBundle[0] |-> builtBundle[16:13]
                           == spatialQ.channelAllocStandard)
        else $error("allocation standard misplaced");
    a_speaker_alloc: assert property (
        builtBundle[0] |-> builtBundle[28:21]
                           == spatialQ.spatialSpeakerAlloc)
        else $error("speaker allocation misplaced");
    a_multi_flags: assert property (
        !builtBundle[0] |-> builtBundle[5] == subQ[0].viewLeft
            && builtBundle[6] == subQ[0].viewRight
            && builtBundle[12:7] == '0)
        else $error("view flags misplaced");
    a_track_fields: assert property (
        !builtBundle[0] |-> builtBundle[15:13] == subQ[0].supplType
            && builtBundle[16] == subQ[0].supplMixed
            && builtBundle[17] == subQ[0].supplPresent
            && builtBundle[19:18] == '0)
        else $error("track fields misplaced");
    a_lang_tag: assert property (
        !builtBundle[0] |-> builtBundle[20] == subQ[0].languageTagValid
            && builtBundle[44:21] == subQ[0].languageTag)
        else $error("language tag misplaced");
    a_sub_stride: assert property (
        !builtBundle[0] |-> builtBundle[84:61] == subQ[1].languageTag
            && builtBundle[124:101] == subQ[2].languageTag
            && builtBundle[164:141] == subQ[3].languageTag)
        else $error("subpacket stride wrong");
    a_field_load: assert property (
        !outReady |=> $stable(metadataBundle))
        else $error("bundle changed between field edges");

    c_spatial_load: cover property (pop && mem[rdPtrQ][0]);
    c_multi_load: cover property (pop && !mem[rdPtrQ][0]);
    c_buffer_full: cover property (wrCommit && !inReady);
    c_bypass_load: cover property (pop && mem[rdPtrQ][amsd_pkg::CTRL_BIT]);

endmodule

// [dv/amsd_device_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// device side: counts inserted, forwarded and filtered packets
// ------------------------------------------------------------
module amsd_device_model #(
    parameter bit KIND_OK = 1'b1
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          vsync,
    input  wire logic                          auxArrive,
    input  wire logic [amsd_pkg::BUNDLE_W-1:0] bundle,
    output      logic [7:0]                    insCnt,
    output      logic [7:0]                    fwdCnt,
    output      logic [7:0]                    dropCnt
);
    logic vsyncQ;
    wire  fieldEdge = vsync & ~vsyncQ;
    // bundle is looked at once, at the field edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vsyncQ  <= 1'b0;
            insCnt  <= 8'h00;
            fwdCnt  <= 8'h00;
            dropCnt <= 8'h00;
        end else begin
            vsyncQ <= vsync;
            if (fieldEdge && bundle[165]) begin
                fwdCnt <= fwdCnt + {7'h00, auxArrive};
            end else if (fieldEdge) begin
                insCnt  <= insCnt + {7'h00, KIND_OK};
                dropCnt <= dropCnt + {7'h00, auxArrive};
            end
        end
    end
endmodule

// [dv/amsd_host_bench.sv]
`timescale 1ns/1ps
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module amsd_host_bench;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [2:0]   hsize = 3'h2;
    logic [31:0]  hwdata = 32'h0;
    logic         vsync = 1'b0;
    logic         aux = 1'b0;
    wire          hreadyout;
    wire          hresp;
    wire  [31:0]  hrdata;
    wire  [165:0] bundle;
    wire  [7:0]   insCnt;
    wire  [7:0]   fwdCnt;
    wire  [7:0]   dropCnt;
    int           errors = 0;
    int           checks = 0;
    int           insE = 0;
    int           fwdE = 0;
    int           dropE = 0;
    logic [165:0] q[$];
    logic [165:0] cur = amsd_pkg::BUNDLE_RST;
    logic [31:0]  regs[6] = '{32'h2, 0, 0, 0, 0, 0};
    logic [7:0]   cnt = 8'h00;
    logic         drop = 1'b0;
    logic [31:0]  r;

    always #12.5 clk = ~clk;

    amsd_host dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .vsync(vsync), .metadataBundle(bundle));
    amsd_device_model dev (.clk(clk), .rst(rst), .vsync(vsync),
        .auxArrive(aux), .bundle(bundle), .insCnt(insCnt),
        .fwdCnt(fwdCnt), .dropCnt(dropCnt));

    // expected bundle from the register copies
    function automatic logic [165:0] build();
        logic [165:0] b;
        b = '0;
        b[165] = regs[0][1];
        b[0] = regs[0][0];
        b[2:1] = regs[0][3:2];
        b[4:3] = regs[0][5:4];
        if (regs[0][0]) begin
            b[9:5] = regs[1][4:0];
            b[16:13] = regs[1][8:5];
            b[28:21] = regs[1][16:9];
        end else begin
            for (int k = 0; k < 4; k++) begin
                b[5+40*k +: 2] = regs[2+k][1:0];
                b[13+40*k +: 3] = regs[2+k][4:2];
                b[16+40*k +: 2] = regs[2+k][6:5];
                b[20+40*k] = regs[2+k][7];
                b[21+40*k +: 24] = regs[2+k][31:8];
            end
        end
        return b;
    endfunction

    // one ahb-lite single transfer
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= amsd_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= amsd_pkg::HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CMP(hresp, 1'b0)
    endtask

    // write plus reference update
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
        if (a < amsd_pkg::OFS_COMMIT) begin
            regs[a[4:2]] = d & (a == 8'h00 ? 32'h3f :
                a == 8'h04 ? 32'h1ffff : 32'hffffffff);
        end
        if (a == amsd_pkg::OFS_COMMIT && q.size() < 2) begin
            q.push_back(build());
        end else if (a == amsd_pkg::OFS_COMMIT) begin
            drop = 1'b1;
        end
        if (a == amsd_pkg::OFS_STATUS && d[4]) begin
            drop = 1'b0;
        end
    endtask

    // register and status readback
    task automatic chk_regs();
        logic [31:0] st;
        for (int i = 0; i < 6; i++) begin
            bus(8'(i * 4), 1'b0, 32'h0, r);
            `CMP(r, regs[i])
        end
        bus(amsd_pkg::OFS_STATUS, 1'b0, 32'h0, r);
        st = {16'h0, cnt, 3'h0, drop, cur[165], q.size() != 0,
              q.size() < 2, cur[0]};
        `CMP(r, st)
    endtask

    // one field: sync pulse, then bundle and device counts
    task automatic field(input logic a);
        aux <= a;
        vsync <= 1'b1;
        if (cur[165]) begin
            fwdE += int'(a);
        end else begin
            insE++;
            dropE += int'(a);
        end
        if (q.size() != 0) begin
            cur = q.pop_front();
            cnt++;
        end
        repeat (4) @(posedge clk);
        vsync <= 1'b0;
        repeat (6) @(posedge clk);
        `CMP(bundle, cur)
        `CMP({insCnt, fwdCnt, dropCnt}, {insE[7:0], fwdE[7:0], dropE[7:0]})
    endtask

    task automatic wrap_up();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] c;
        void'($urandom(64));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CMP(bundle, amsd_pkg::BUNDLE_RST)
        chk_regs();
        for (int i = 0; i < 8; i++) begin
            c = $urandom();
            c[1:0] = 2'(i);
            wr(amsd_pkg::OFS_CTRL, c);
            for (int k = 0; k < 5; k++) begin
                wr(8'(4 + 4 * k), $urandom());
            end
            chk_regs();
            wr(amsd_pkg::OFS_COMMIT, 32'h0);
            field(1'($urandom()));
            chk_regs();
        end
        // overflow, sticky clear, drain, empty field
        repeat (3) wr(amsd_pkg::OFS_COMMIT, 32'h0);
        chk_regs();
        wr(amsd_pkg::OFS_STATUS, 32'h10);
        chk_regs();
        field(1'b1);
        field(1'b0);
        wr(amsd_pkg::OFS_CTRL, 32'h01);
        field(1'b1);
        chk_regs();
        // unmapped place reads zero, write ignored
        wr(8'h40, $urandom());
        bus(8'h40, 1'b0, 32'h0, r);
        `CMP(r, 32'h0)
        chk_regs();
        wrap_up();
    end

    // hang guard
    initial begin
        #(25 * 20000);
        errors++;
        wrap_up();
    end
endmodule
